// >>> logic/nvs_defs.svh
// Timing counts, unlock addresses and widths for the save/restore host
`ifndef NVS_DEFS_SVH
`define NVS_DEFS_SVH

`define NVS_CLK_NS 8
`define NVS_ADDR_W 15
`define NVS_DATA_W 8
`define NVS_CNT_W 22
`define NVS_SYNC_W 10
`define NVS_SYNC_DQ_LSB 0
`define NVS_SYNC_BUSY_BIT 8
`define NVS_SYNC_PF_BIT 9

// Least times, rounded up to whole cycles
`define NVS_ACCESS_NS 45
`define NVS_SYNC_LAT_CYC 3
`define NVS_STROBE_CYC ((`NVS_ACCESS_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS + `NVS_SYNC_LAT_CYC)
`define NVS_GRACE_NS 25000
`define NVS_GRACE_CYC ((`NVS_GRACE_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_RESTORE_NS 20000
`define NVS_RESTORE_CYC ((`NVS_RESTORE_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_SAVE_NS 12500000
`define NVS_SAVE_CYC ((`NVS_SAVE_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_PUR_NS 20000000
`define NVS_PUR_CYC ((`NVS_PUR_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)

// Unlock sequence; top address line left low as the device ignores it
`define NVS_SEQ_LAST 3'h5
`define NVS_SEQ_A0 15'h0E38
`define NVS_SEQ_A1 15'h31C7
`define NVS_SEQ_A2 15'h03E0
`define NVS_SEQ_A3 15'h3C1F
`define NVS_SEQ_A4 15'h303F
`define NVS_SEQ_SAVE 15'h0FC0
`define NVS_SEQ_RESTORE 15'h0C63

`endif

// >>> logic/nvs_host.sv
// Host controller driving a save/restore static RAM through its pins
// Function
// - Write while chip select and write strobe low, store-busy high.
// - Address stays stable from before write until strobes rise.
// - Output gate held high through every write.
// - Six reads at fixed addresses, last 0x0FC0, start a save.
// - Same five reads then 0x0C63 start a restore.
// - Any other access inside the sequence aborts it.
// - Sequence uses reads only; output gate need not be low.
// - Read while chip select and gate low, write strobe and busy high.
`include "nvs_defs.svh"
module nvs_host
  import nvs_pkg::*;
#(
  parameter int SAVE_CYC = `NVS_SAVE_CYC,
  parameter int PUR_CYC = `NVS_PUR_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_req_valid,
  input wire nvs_req_type i_req,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output nvs_rsp_type o_rsp,
  output logic o_busy,
  output nvs_bus_type o_bus,
  output logic [7:0] o_data_pins_out,
  output logic o_data_pins_oe,
  input wire logic [7:0] i_data_pins_in,
  output logic o_store_busy_n_out,
  output logic o_store_busy_n_oe,
  input wire logic i_store_busy_n,
  input wire logic i_power_fail
);
  logic rst_a_reg;
  logic rst_b_reg;
  logic [`NVS_SYNC_W-1:0] pins_async;
  logic [`NVS_SYNC_W-1:0] pins_sync;
  logic busy_high;
  logic pf_low_supply;
  nvs_state_type state_reg;
  nvs_req_type req_reg;
  logic seq_reg;
  logic [2:0] idx_reg;
  logic [`NVS_CNT_W-1:0] cnt_reg;

  // Top address line kept low for every unlock address
  function automatic logic [14:0] unlock_addr(input logic [2:0] idx,
                                              input logic restore);
    unique case (idx)
      3'h0: unlock_addr = `NVS_SEQ_A0;
      3'h1: unlock_addr = `NVS_SEQ_A1;
      3'h2: unlock_addr = `NVS_SEQ_A2;
      3'h3: unlock_addr = `NVS_SEQ_A3;
      3'h4: unlock_addr = `NVS_SEQ_A4;
      default: unlock_addr = restore ? `NVS_SEQ_RESTORE : `NVS_SEQ_SAVE;
    endcase
  endfunction

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end

  assign pins_async = {i_power_fail, i_store_busy_n, i_data_pins_in};

  nvs_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_b_reg),
    .i_async(pins_async),
    .o_sync(pins_sync)
  );

  assign busy_high = pins_sync[`NVS_SYNC_BUSY_BIT];
  assign pf_low_supply = pins_sync[`NVS_SYNC_PF_BIT];

  always_ff @(posedge i_clk_sys or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      state_reg <= NVS_ST_BOOT;
      req_reg <= '0;
      seq_reg <= 1'b0;
      idx_reg <= 3'h0;
      cnt_reg <= `NVS_CNT_W'(PUR_CYC);
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp <= '0;
      o_busy <= 1'b1;
      o_bus <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 15'h0000};
      o_data_pins_out <= 8'h00;
      o_data_pins_oe <= 1'b0;
      o_store_busy_n_oe <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      unique case (state_reg)
        NVS_ST_BOOT: begin
          // Power-up restore time; no access until it is over
          if (cnt_reg > `NVS_CNT_W'(1)) begin
            cnt_reg <= cnt_reg - `NVS_CNT_W'(1);
          end else begin
            state_reg <= NVS_ST_IDLE;
            o_req_ready <= 1'b1;
            o_busy <= 1'b0;
          end
        end
        NVS_ST_IDLE: begin
          if (pf_low_supply) begin
            state_reg <= NVS_ST_POWER_FAIL;
            o_req_ready <= 1'b0;
            o_busy <= 1'b1;
          end else if (i_req_valid && o_req_ready) begin
            req_reg <= i_req;
            o_req_ready <= 1'b0;
            o_busy <= 1'b1;
            seq_reg <= (i_req.op == NVS_OP_SOFT_SAVE) ||
                       (i_req.op == NVS_OP_SOFT_RESTORE);
            idx_reg <= 3'h0;
            if (i_req.op == NVS_OP_PIN_SAVE) begin
              // Pull the busy pin to request a save
              o_store_busy_n_oe <= 1'b1;
              cnt_reg <= `NVS_CNT_W'(`NVS_GRACE_CYC);
              state_reg <= NVS_ST_GRACE;
            end else if (!busy_high) begin
              // Device saving: refuse rather than start a blocked access
              o_rsp_valid <= 1'b1;
              o_rsp <= '{err: 1'b1, rdata: 8'h00};
              o_req_ready <= 1'b1;
              o_busy <= 1'b0;
            end else begin
              o_bus.addr <= (i_req.op == NVS_OP_SOFT_SAVE ||
                             i_req.op == NVS_OP_SOFT_RESTORE) ?
                            unlock_addr(3'h0, 1'b0) : i_req.addr;
              state_reg <= NVS_ST_SETUP;
            end
          end
        end
        NVS_ST_SETUP: begin
          // Address already stable for a cycle before the strobes fall
          o_bus.ce_n <= 1'b0;
          cnt_reg <= `NVS_CNT_W'(`NVS_STROBE_CYC);
          if (!seq_reg && req_reg.op == NVS_OP_WRITE) begin
            o_bus.we_n <= 1'b0;
            o_bus.oe_n <= 1'b1;
            o_data_pins_out <= req_reg.wdata;
            o_data_pins_oe <= 1'b1;
          end else begin
            // Sequence reads are chip-select clocked with the gate high
            o_bus.oe_n <= seq_reg;
            o_bus.we_n <= 1'b1;
          end
          state_reg <= NVS_ST_STROBE;
        end
        NVS_ST_STROBE: begin
          if (cnt_reg > `NVS_CNT_W'(1)) begin
            cnt_reg <= cnt_reg - `NVS_CNT_W'(1);
          end else begin
            o_rsp.rdata <= pins_sync[7:0];
            // Strobes always rise between cycles, giving a fresh edge
            o_bus.ce_n <= 1'b1;
            o_bus.we_n <= 1'b1;
            o_bus.oe_n <= 1'b1;
            state_reg <= NVS_ST_HOLD;
          end
        end
        NVS_ST_HOLD: begin
          o_data_pins_oe <= 1'b0;
          // One atomic command: nothing can slip inside the sequence
          if (seq_reg && idx_reg != `NVS_SEQ_LAST) begin
            idx_reg <= idx_reg + 3'h1;
            o_bus.addr <= unlock_addr(idx_reg + 3'h1,
                                      req_reg.op == NVS_OP_SOFT_RESTORE);
            state_reg <= NVS_ST_SETUP;
          end else if (seq_reg && req_reg.op == NVS_OP_SOFT_RESTORE) begin
            cnt_reg <= `NVS_CNT_W'(`NVS_RESTORE_CYC);
            state_reg <= NVS_ST_WAIT_RESTORE;
          end else if (seq_reg) begin
            cnt_reg <= `NVS_CNT_W'(SAVE_CYC);
            state_reg <= NVS_ST_WAIT_SAVE;
          end else begin
            o_rsp_valid <= 1'b1;
            o_rsp.err <= 1'b0;
            o_req_ready <= 1'b1;
            o_busy <= 1'b0;
            state_reg <= NVS_ST_IDLE;
          end
        end
        NVS_ST_GRACE: begin
          if (cnt_reg > `NVS_CNT_W'(1)) begin
            cnt_reg <= cnt_reg - `NVS_CNT_W'(1);
          end else begin
            // Device keeps the pin low itself if it saves
            o_store_busy_n_oe <= 1'b0;
            cnt_reg <= `NVS_CNT_W'(SAVE_CYC);
            state_reg <= NVS_ST_WAIT_BUSY;
          end
        end
        NVS_ST_WAIT_SAVE: begin
          if (cnt_reg > `NVS_CNT_W'(1)) begin
            cnt_reg <= cnt_reg - `NVS_CNT_W'(1);
          end else begin
            state_reg <= NVS_ST_WAIT_BUSY;
          end
        end
        NVS_ST_WAIT_BUSY: begin
          // Clean device skips the save and frees the pin early
          if (cnt_reg > `NVS_CNT_W'(1) && !busy_high) begin
            cnt_reg <= cnt_reg - `NVS_CNT_W'(1);
          end else if (busy_high) begin
            o_rsp_valid <= 1'b1;
            o_rsp.err <= 1'b0;
            o_req_ready <= 1'b1;
            o_busy <= 1'b0;
            state_reg <= NVS_ST_IDLE;
          end
        end
        NVS_ST_WAIT_RESTORE: begin
          if (cnt_reg > `NVS_CNT_W'(1)) begin
            cnt_reg <= cnt_reg - `NVS_CNT_W'(1);
          end else begin
            o_rsp_valid <= 1'b1;
            o_rsp.err <= 1'b0;
            o_req_ready <= 1'b1;
            o_busy <= 1'b0;
            state_reg <= NVS_ST_IDLE;
          end
        end
        NVS_ST_POWER_FAIL: begin
          // Low supply: no writes or saves; device saves from its capacitor
          if (!pf_low_supply) begin
            cnt_reg <= `NVS_CNT_W'(PUR_CYC);
            state_reg <= NVS_ST_BOOT;
          end
        end
        default: begin
          state_reg <= NVS_ST_IDLE;
          o_req_ready <= 1'b1;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: only ever drives low
  always_ff @(posedge i_clk_sys or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      o_store_busy_n_out <= 1'b0;
    end else begin
      o_store_busy_n_out <= 1'b0;
    end
  end
endmodule // nvs_host

// >>> logic/nvs_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages 2 and 3 agree
`include "nvs_defs.svh"
module nvs_pin_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [`NVS_SYNC_W-1:0] i_async,
  output logic [`NVS_SYNC_W-1:0] o_sync
);
  genvar gi;
  generate
    for (gi = 0; gi < `NVS_SYNC_W; gi = gi + 1) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          o_sync[gi] <= 1'b0;
        end else begin
          s1_reg <= i_async[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // Stage 1 feeds only stage 2; the filter looks at 2 and 3
          if (s2_reg == s3_reg) begin
            o_sync[gi] <= s3_reg;
          end
        end
      end
    end
  endgenerate
endmodule // nvs_pin_sync

// >>> logic/nvs_pkg.sv
// Types shared by the save/restore host
package nvs_pkg;
  typedef enum logic [2:0] {
    NVS_OP_READ,
    NVS_OP_WRITE,
    NVS_OP_SOFT_SAVE,
    NVS_OP_SOFT_RESTORE,
    NVS_OP_PIN_SAVE
  } nvs_op_type;

  typedef struct packed {
    nvs_op_type op;
    logic [14:0] addr;
    logic [7:0] wdata;
  } nvs_req_type;

  typedef struct packed {
    logic err;
    logic [7:0] rdata;
  } nvs_rsp_type;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [14:0] addr;
  } nvs_bus_type;

  typedef enum logic [3:0] {
    NVS_ST_BOOT,
    NVS_ST_IDLE,
    NVS_ST_SETUP,
    NVS_ST_STROBE,
    NVS_ST_HOLD,
    NVS_ST_GRACE,
    NVS_ST_WAIT_SAVE,
    NVS_ST_WAIT_BUSY,
    NVS_ST_WAIT_RESTORE,
    NVS_ST_POWER_FAIL
  } nvs_state_type;
endpackage

// >>> verification/nvs_dev_model.sv
// Behavioural save/restore memory for the host bench
module nvs_dev_model
  import nvs_pkg::*;
(
  input wire nvs_bus_type i_bus,
  input wire logic [7:0] i_data,
  input wire logic i_busy_n,
  input wire logic i_pf,
  output logic [7:0] o_data,
  output logic o_data_en,
  output logic o_busy_low,
  output int o_saves,
  output int o_restores
);
  timeunit 1ns;
  timeprecision 1ps;
  // Durations kept short so the run stays brief
  localparam int GRACE_NS = 1000;
  localparam int SAVE_NS = 300;
  localparam int RESTORE_NS = 1000;
  localparam int PUR_NS = 200;
  localparam logic [13:0] SEQ [6] = '{14'h0E38, 14'h31C7, 14'h03E0,
    14'h3C1F, 14'h303F, 14'h0FC0};
  logic [7:0] mem [32768];
  logic [7:0] nv [32768];
  logic [7:0] wd;
  logic [2:0] idx;
  logic dirty, off, ok;
  wire wr_n = i_bus.ce_n | i_bus.we_n;
  initial begin
    mem = '{default: 8'h00};
    nv = mem;
    {idx, dirty, off, o_busy_low} = '0;
    o_saves = 0;
    o_restores = 0;
  end
  task automatic save();
    off = 1;
    o_busy_low = 1;
    #SAVE_NS nv = mem;
    dirty = 0;
    o_saves++;
    o_busy_low = 0;
    wait (i_busy_n);
    off = 0;
  endtask
  task automatic restore(int ns);
    off = 1;
    #(ns) mem = nv;
    dirty = 0;
    o_restores++;
    off = 0;
  endtask
  assign o_data_en = !i_bus.ce_n && !i_bus.oe_n && i_bus.we_n &&
    i_busy_n && !off;
  assign o_data = mem[i_bus.addr];
  always @(negedge wr_n) begin
    idx = 3'h0;
    // A write already low when access returns waits for a fresh edge
    ok = i_busy_n && !off && !i_pf;
    #20 wd = i_data;
  end
  always @(posedge wr_n) begin
    if (ok && !i_pf) begin
      mem[i_bus.addr] = wd;
      dirty = 1;
    end
  end
  always @(negedge i_bus.ce_n) begin
    if (i_bus.we_n && !off) begin
      if (idx == 3'h5 && i_bus.addr[13:0] == 14'h0C63) begin
        idx = 3'h0;
        restore(RESTORE_NS);
      end else if (i_bus.addr[13:0] == SEQ[idx]) begin
        idx = idx + 3'h1;
      end else begin
        idx = {2'h0, i_bus.addr[13:0] == SEQ[0]};
      end
      if (idx == 3'h6) begin
        idx = 3'h0;
        save();
      end
    end
  end
  always @(negedge i_busy_n) begin
    if (!o_busy_low) begin
      #GRACE_NS;
      if (dirty && !i_pf) save();
    end
  end
  always @(posedge i_pf) if (dirty) save();
  always @(negedge i_pf) restore(PUR_NS);
endmodule // nvs_dev_model

// >>> verification/nvs_host_sva.sv
// Pin-level checks on the save/restore host
module nvs_host_sva
  import nvs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic o_req_ready,
  input wire logic o_busy,
  input wire logic o_store_busy_n_out,
  input wire logic o_store_busy_n_oe,
  input wire nvs_bus_type o_bus,
  input wire logic o_data_pins_oe,
  input wire logic i_store_busy_n,
  input wire logic i_power_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  AST_WR_PIN_HIGH: assert property ($fell(o_bus.we_n) |-> i_store_busy_n)
    else $error("write strobe with busy pin low");
  AST_WR_DATA: assert property ($fell(o_bus.we_n) |-> o_data_pins_oe)
    else $error("write strobe without data drive");
  AST_WR_ADDR: assert property (!o_bus.ce_n && !o_bus.we_n |=>
    $stable(o_bus.addr)) else $error("address moved in write");
  AST_WR_GATE: assert property (!o_bus.we_n |-> o_bus.oe_n)
    else $error("output gate low in write");
  AST_DRV_GATE: assert property (o_data_pins_oe |-> o_bus.oe_n)
    else $error("data driven with gate low");
  AST_STROBE: assert property ($fell(o_bus.ce_n) |-> (!o_bus.ce_n)[*8])
    else $error("chip select strobe too short");
  // Sync delay of the supply flag is allowed for
  AST_PF_WR: assert property (i_power_fail[*7] |-> !$fell(o_bus.we_n))
    else $error("write in power fail");
  AST_PF_RDY: assert property (i_power_fail[*7] |-> !o_req_ready)
    else $error("ready in power fail");
  AST_BUSY_RDY: assert property (o_busy != o_req_ready)
    else $error("busy flag and ready disagree");
  AST_PIN_NO_WR: assert property (o_store_busy_n_oe |-> o_bus.we_n)
    else $error("write strobe while pulling busy pin");
  AST_OD_LOW: assert property (o_store_busy_n_oe |-> !o_store_busy_n_out)
    else $error("busy pin driven high");
endmodule // nvs_host_sva

bind nvs_host nvs_host_sva i_nvs_host_sva (.i_clk_sys, .i_resetn,
  .o_req_ready, .o_busy, .o_store_busy_n_out, .o_store_busy_n_oe,
  .o_bus, .o_data_pins_oe, .i_store_busy_n, .i_power_fail);

// >>> verification/nvs_host_tb_top.sv
// Self-checking bench for the save/restore host
module nvs_host_tb_top
  import nvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0;
  logic i_resetn = 0;
  logic vld = 0;
  logic pf = 0;
  logic ext_low = 0;
  logic rdy, rv, dq_oe, sb_oe, dev_en, dev_low, sb_out, bsy;
  logic [7:0] dq_out, dev_dq;
  logic [7:0] flt = 8'h5A;
  nvs_req_type req = '0;
  nvs_rsp_type rsp;
  nvs_bus_type bus;
  int saves, rests;
  int err_total = 0;
  int check_count = 0;
  // Released data lines toggle so a stale byte never reads back
  wire [7:0] dq = dq_oe ? dq_out : (dev_en ? dev_dq : flt);
  // Open drain with pull-up: only a driven low value pulls the pin
  wire sb_n = !((sb_oe && !sb_out) || dev_low || ext_low);
  always #4 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) flt <= ~flt;
  nvs_host #(.SAVE_CYC(50), .PUR_CYC(40)) i_nvs_host (
    .i_clk_sys, .i_resetn, .i_req_valid(vld), .i_req(req),
    .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp(rsp), .o_busy(bsy),
    .o_bus(bus), .o_data_pins_out(dq_out), .o_data_pins_oe(dq_oe),
    .i_data_pins_in(dq), .o_store_busy_n_out(sb_out),
    .o_store_busy_n_oe(sb_oe), .i_store_busy_n(sb_n),
    .i_power_fail(pf));
  nvs_dev_model i_nvs_dev_model (.i_bus(bus), .i_data(dq),
    .i_busy_n(sb_n), .i_pf(pf), .o_data(dev_dq), .o_data_en(dev_en),
    .o_busy_low(dev_low), .o_saves(saves), .o_restores(rests));
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(nvs_op_type o, logic [14:0] a, logic [7:0] d);
    int n = 0;
    while (rdy !== 1'b1 && n < 9000) begin
      n++;
      @(negedge i_clk_sys);
    end
    req = '{o, a, d};
    vld = 1;
    @(negedge i_clk_sys);
    vld = 0;
    n = 0;
    while (rv !== 1'b1 && n < 40000) begin
      n++;
      @(negedge i_clk_sys);
    end
    chk(rv, 1);
  endtask
  task automatic t_wr_rd();
    op(NVS_OP_WRITE, 15'h1234, 8'hA5);
    chk(rsp.err, 0);
    op(NVS_OP_READ, 15'h1234, 8'h00);
    chk(rsp.rdata, 8'hA5);
  endtask
  task automatic t_soft();
    int r = rests;
    op(NVS_OP_SOFT_SAVE, 15'h0000, 8'h00);
    chk(saves, 1);
    op(NVS_OP_SOFT_SAVE, 15'h0000, 8'h00);
    chk(saves, 2);
    op(NVS_OP_WRITE, 15'h1234, 8'h3C);
    op(NVS_OP_SOFT_RESTORE, 15'h0000, 8'h00);
    chk(rests, r + 1);
    op(NVS_OP_READ, 15'h1234, 8'h00);
    chk(rsp.rdata, 8'hA5);
  endtask
  task automatic t_pin();
    op(NVS_OP_PIN_SAVE, 15'h0000, 8'h00);
    chk(saves, 2);
    op(NVS_OP_WRITE, 15'h0042, 8'h77);
    op(NVS_OP_PIN_SAVE, 15'h0000, 8'h00);
    chk(saves, 3);
  endtask
  task automatic t_pf();
    int r = rests;
    op(NVS_OP_WRITE, 15'h1234, 8'h99);
    pf = 1;
    repeat (60) @(negedge i_clk_sys);
    chk(rdy, 0);
    chk(bsy, 1);
    chk(saves, 4);
    pf = 0;
    op(NVS_OP_READ, 15'h1234, 8'h00);
    chk(rsp.rdata, 8'h99);
    chk(rests, r + 1);
  endtask
  task automatic t_busy();
    ext_low = 1;
    repeat (8) @(negedge i_clk_sys);
    op(NVS_OP_READ, 15'h1234, 8'h00);
    chk(rsp.err, 1);
    // Let the request line rest a cycle between the two refused calls
    @(negedge i_clk_sys);
    op(NVS_OP_WRITE, 15'h1234, 8'h11);
    chk(rsp.err, 1);
    ext_low = 0;
    // Synchroniser latency before the pin is seen high again
    repeat (8) @(negedge i_clk_sys);
    op(NVS_OP_READ, 15'h1234, 8'h00);
    chk(rsp.err, 0);
    chk(rsp.rdata, 8'h99);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_resetn = 1;
    t_wr_rd();
    t_soft();
    t_pin();
    t_pf();
    t_busy();
    end_of_test();
  end
  // Two pin saves (some 50 us) and a soft restore (some 20 us) dominate the run
  initial begin
    #300us;
    err_total++;
    end_of_test();
  end
endmodule // nvs_host_tb_top
